// ---- rtl/drive_input_pkg.sv ----
// package: constants and carrier types for the input terminal command logic
package drive_input_pkg;
    // terminal function codes
    localparam logic [5:0] FUNC_START = 6'h12;  // 18
    localparam logic [5:0] FUNC_STOP = 6'h13;   // 19
    localparam logic [5:0] FUNC_DIR = 6'h14;    // 20
    localparam logic [5:0] FUNC_PID = 6'h15;    // 21
    localparam logic [5:0] FUNC_INT_CLR = 6'h16; // 22
    localparam logic [5:0] FUNC_UP = 6'h18;     // 24
    localparam logic [5:0] FUNC_DOWN = 6'h19;   // 25
    localparam logic [5:0] FUNC_TRIM_CLR = 6'h1a; // 26
    localparam logic [5:0] FUNC_LOCAL = 6'h1b;  // 27
    localparam logic [5:0] FUNC_REMOTE = 6'h1c; // 28
    localparam logic [5:0] FUNC_LIM_SEL0 = 6'h1e; // 30
    localparam logic [5:0] FUNC_LIM_SEL1 = 6'h1f; // 31
    // command source codes, torque mode and trim memory selects
    localparam logic [1:0] FREQ_SRC_POT = 2'h0;
    localparam logic [1:0] FREQ_SRC_TERM = 2'h1;
    localparam logic [1:0] FREQ_SRC_OPER = 2'h2;
    localparam logic [1:0] RUN_SRC_TERM = 2'h1;
    localparam logic [1:0] RUN_SRC_OPER = 2'h2;
    localparam logic TRQ_MODE_TERMINAL = 1'h1;
    localparam logic TRIM_KEEP = 1'h1;
    // torque limit in percent when limiting is released
    localparam logic [7:0] TORQUE_MAX_PCT = 8'hc8; // 200 %
    // ramp time in 0.1 s units
    localparam logic [15:0] RAMP_DEFAULT = 16'h012c; // 30.0 s
    // frequency trim step tick
    localparam int TRIM_TICK_US = 1000;
    localparam int CLK_MHZ = 40;
    localparam int TRIM_TICK_CYCLES = TRIM_TICK_US * CLK_MHZ;

    // terminal function levels straight from the pins, active high
    typedef struct packed {
        logic start;
        logic stop;
        logic dir;
        logic fwd;
        logic rev;
        logic pid_dis;
        logic int_clr;
        logic up;
        logic down;
        logic trim_clr;
        logic oper;
        logic local_force;
        logic remote_force;
        logic limit_en;
        logic lim_sel0;
        logic lim_sel1;
        logic [2:0] ramp_sel;
        logic p_only;
    } term_t;

    // which functions are assigned to a terminal
    typedef struct packed {
        logic start;
        logic stop;
        logic dir;
        logic limit_en;
    } assign_t;
endpackage

// ---- rtl/trim_store.sv ----
// trim store: retained up/down frequency memory with registered read data
module trim_store #(
    parameter int WIDTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem;

    // holder survives core reset; power loss handled by the caller's choice
    always_ff @(posedge i_core_clk) begin
        if (i_wr) begin
            mem <= i_data;
        end
    end

    // registered read
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data <= '0;
        end else begin
            o_data <= mem;
        end
    end
endmodule

// ---- rtl/drive_input_terminal_functions.sv ----
// drive command logic driven by multi-function input terminals
// Function
// - three-wire needs start, stop, direction all assigned
// - assigned stop disables maintained forward/reverse
// - pid disable terminal on turns PID_DISABLE_INPUT off
// - integral clear rising edge zeroes integral
// - up raises, down lowers, none holds
// - trimming only with frequency source 01/02
// - ignore trim under analog command or jog
// - trimming ramps with standard accel/decel times
// - memory 0 restores base, 1 keeps trim
// - trim clear edge restores base frequency
// - override takes frequency and run from panel
// - override change while running stops motor
// - terminal mode picks quadrant limit by selectors
// - enable off gives 200 percent; unassigned uses the quadrant limits
// - ramp select code picks pair 1..7
// - local/remote force sets command sources
// - both forces on cancels forcing
// - speed regulator switches P or PI
module drive_input_terminal_functions
    import drive_input_pkg::*;
#(
    parameter int FREQ_W = 16,
    parameter int TICK_CYCLES = TRIM_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire drive_input_pkg::term_t i_term,
    input wire drive_input_pkg::assign_t i_assigned,
    input wire logic [1:0] i_freq_src,
    input wire logic [1:0] i_run_src,
    input wire logic i_multi_speed,
    input wire logic i_analog_cmd,
    input wire logic i_jog,
    input wire logic i_trim_keep,
    input wire logic i_power_up,
    input wire logic [FREQ_W-1:0] i_base_freq,
    input wire logic [FREQ_W-1:0] i_max_freq,
    input wire logic [FREQ_W-1:0] i_trim_step,
    input wire logic i_trq_mode,
    input wire logic [31:0] i_quad_limits,
    input wire logic i_regen,
    input wire logic [15:0] i_std_accel,
    input wire logic [15:0] i_std_decel,
    input wire logic [223:0] i_ramp_pairs,
    input wire logic i_panel_run,
    input wire logic i_panel_dir,
    input wire logic [FREQ_W-1:0] i_panel_freq,
    input wire logic i_running,
    output logic o_run,
    output logic o_reverse,
    output logic o_three_wire,
    output logic o_pid_enable,
    output logic o_integral_clear,
    output logic [FREQ_W-1:0] o_freq,
    output logic o_freq_from_panel,
    output logic [1:0] o_eff_freq_src,
    output logic [1:0] o_eff_run_src,
    output logic [7:0] o_torque_limit,
    output logic [15:0] o_accel,
    output logic [15:0] o_decel,
    output logic o_p_only,
    output logic o_override_stop
);
    import drive_input_pkg::*;

    term_t t_meta;
    term_t t;
    term_t t_q;
    logic three_wire;
    logic trim_allowed;
    logic [FREQ_W-1:0] trim_freq;
    logic [FREQ_W-1:0] stored_freq;
    logic store_wr;
    logic restore_pend;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
    logic tick;
    logic stop_latch;
    logic run_cmd;
    logic [1:0] next_freq_src;
    logic [1:0] next_run_src;

    // pick a 16-bit ramp time pair member out of the packed table
    function automatic logic [15:0] ramp_of(input logic [223:0] tbl, input logic [2:0] code,
                                            input logic decel);
        logic [7:0] idx;
        idx = 8'(({5'h0, code} - 8'h1) * 8'h2 + {7'h0, decel});
        return tbl[idx*16 +: 16];
    endfunction

    // terminal pins pass two flip-flops
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            t_meta <= '0;
            t <= '0;
            t_q <= '0;
        end else begin
            t_meta <= i_term;
            t <= t_meta;
            t_q <= t;
        end
    end

    // three-wire only with all three functions assigned
    assign three_wire = i_assigned.start && i_assigned.stop && i_assigned.dir;

    // trim gating by source, analog and jog
    assign trim_allowed = ((i_freq_src == FREQ_SRC_OPER) ||
                           (i_freq_src == FREQ_SRC_TERM && i_multi_speed)) &&
                          !i_analog_cmd && !i_jog;

    // forced command sources
    always_comb begin
        next_freq_src = i_freq_src;
        next_run_src = i_run_src;
        if (t.local_force && !t.remote_force) begin
            next_freq_src = FREQ_SRC_POT;
            next_run_src = RUN_SRC_OPER;
        end else if (t.remote_force && !t.local_force) begin
            next_freq_src = FREQ_SRC_TERM;
            next_run_src = RUN_SRC_TERM;
        end
        // both on leaves the configured sources untouched
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_eff_freq_src <= 2'h0;
            o_eff_run_src <= 2'h0;
        end else begin
            o_eff_freq_src <= next_freq_src;
            o_eff_run_src <= next_run_src;
        end
    end

    // three-wire latch: start sets, open stop clears
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stop_latch <= 1'b0;
        end else if (!three_wire || !t.stop) begin
            stop_latch <= 1'b0;
        end else if (t.start) begin
            stop_latch <= 1'b1;
        end
    end

    // run command selection; stop assignment mutes forward/reverse
    always_comb begin
        if (t.oper) begin
            run_cmd = i_panel_run;
        end else if (i_assigned.stop) begin
            run_cmd = three_wire && stop_latch;
        end else begin
            run_cmd = t.fwd ^ t.rev;
        end
    end

    // override change while running stops until fresh run command
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_override_stop <= 1'b0;
        end else if (t.oper != t_q.oper && i_running) begin
            o_override_stop <= 1'b1;
        end else if (!run_cmd) begin
            o_override_stop <= 1'b0;
        end
    end

    // run and direction outputs
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_run <= 1'b0;
            o_reverse <= 1'b0;
            o_three_wire <= 1'b0;
        end else begin
            o_run <= run_cmd && !o_override_stop && !(t.oper != t_q.oper && i_running);
            o_three_wire <= three_wire;
            if (t.oper) begin
                o_reverse <= i_panel_dir;
            end else if (three_wire) begin
                o_reverse <= t.dir;
            end else begin
                o_reverse <= t.rev && !t.fwd && !i_assigned.stop;
            end
        end
    end

    // PID_DISABLE_INPUT enable and integral clear pulse
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pid_enable <= 1'b1;
            o_integral_clear <= 1'b0;
            o_p_only <= 1'b0;
        end else begin
            o_pid_enable <= !t.pid_dis;
            o_integral_clear <= t.int_clr && !t_q.int_clr;
            o_p_only <= t.p_only;
        end
    end

    // trim step tick divider
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == ($bits(tick_cnt))'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // retained trim value
    trim_store #(
        .WIDTH(FREQ_W)
    ) u_trim_store (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_wr(store_wr),
        .i_data(trim_freq),
        .o_data(stored_freq)
    );

    assign store_wr = !restore_pend;

    // trimmed setpoint: power-up restore, clear, up/down stepping
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            trim_freq <= '0;
            restore_pend <= 1'b1;
        end else if (restore_pend) begin
            if (!i_power_up) begin
                // wait for i_power_up to drop before taking the stored value
                restore_pend <= 1'b0;
                trim_freq <= (i_trim_keep == TRIM_KEEP) ? stored_freq : i_base_freq;
            end
        end else if (t.trim_clr && !t_q.trim_clr) begin
            trim_freq <= i_base_freq;
        end else if (trim_allowed && tick) begin
            if (t.up && !t.down && trim_freq <= i_max_freq - i_trim_step) begin
                trim_freq <= trim_freq + i_trim_step;
            end else if (t.down && !t.up && trim_freq >= i_trim_step) begin
                trim_freq <= trim_freq - i_trim_step;
            end
        end
    end

    // output frequency: panel override or trimmed setpoint
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_freq <= '0;
            o_freq_from_panel <= 1'b0;
        end else begin
            o_freq_from_panel <= t.oper;
            o_freq <= t.oper ? i_panel_freq : trim_freq;
        end
    end

    // torque limit by quadrant selectors and enable
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_torque_limit <= TORQUE_MAX_PCT;
        end else if (i_assigned.limit_en && !t.limit_en) begin
            o_torque_limit <= TORQUE_MAX_PCT;
        end else if (i_trq_mode == TRQ_MODE_TERMINAL) begin
            o_torque_limit <= i_quad_limits[{t.lim_sel1, t.lim_sel0}*8 +: 8];
        end else begin
            // selectors ignored: direction and regen pick the quadrant
            o_torque_limit <= i_quad_limits[{o_reverse, i_regen}*8 +: 8];
        end
    end

    // ramp times: standard while trimming or code zero
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_accel <= RAMP_DEFAULT;
            o_decel <= RAMP_DEFAULT;
        end else if ((t.up || t.down) && trim_allowed) begin
            o_accel <= i_std_accel;
            o_decel <= i_std_decel;
        end else if (t.ramp_sel == 3'h0) begin
            o_accel <= i_std_accel;
            o_decel <= i_std_decel;
        end else begin
            o_accel <= ramp_of(i_ramp_pairs, t.ramp_sel, 1'b0);
            o_decel <= ramp_of(i_ramp_pairs, t.ramp_sel, 1'b1);
        end
    end

    // checks
    sequence override_flip_s;
        (t.oper != t_q.oper) && i_running;
    endsequence

    sequence start_press_s;
        three_wire && t.stop && t.start;
    endsequence

    sequence stop_open_s;
        three_wire && !t.stop;
    endsequence

    override_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        override_flip_s |=> !o_run)
        else $error("run kept after override change");
    pid_disable_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        t.pid_dis |=> !o_pid_enable)
        else $error("pid stayed enabled");
    integral_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_integral_clear |=> !o_integral_clear)
        else $error("clear not a pulse");
    three_wire_cfg_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !three_wire |=> !stop_latch)
        else $error("latch without three-wire");
    start_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        start_press_s |=> stop_latch)
        else $error("start not latched");
    stop_release_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        stop_open_s |=> !stop_latch)
        else $error("run latch kept after stop opened");
    stop_mutes_fw_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_assigned.stop && !three_wire && !t.oper) |=> !o_run)
        else $error("forward/reverse not muted");
    local_force_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (t.local_force && !t.remote_force) |=> (o_eff_freq_src == FREQ_SRC_POT && o_eff_run_src == RUN_SRC_OPER))
        else $error("local forcing missing");
    force_both_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (t.local_force && t.remote_force) |=> o_eff_freq_src == $past(i_freq_src))
        else $error("forcing applied with both on");
    panel_freq_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        t.oper |=> o_freq == $past(i_panel_freq))
        else $error("panel frequency not used");
    torque_max_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_assigned.limit_en && !t.limit_en) |=> o_torque_limit == TORQUE_MAX_PCT)
        else $error("limit not released");
    ramp_std_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (t.ramp_sel == 3'h0) |=> o_accel == $past(i_std_accel))
        else $error("standard ramp not used");
    trim_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (!restore_pend && !t.up && !t.down && !(t.trim_clr && !t_q.trim_clr)) |=> $stable(trim_freq))
        else $error("trim moved without input");
    trim_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (!restore_pend && !trim_allowed && !(t.trim_clr && !t_q.trim_clr)) |=> $stable(trim_freq))
        else $error("trim moved while gated");
endmodule

// ---- verification/terminal_switches.sv ----
// partner model: external switches feeding the terminal levels
module terminal_switches
    import drive_input_pkg::*;
(
    input wire drive_input_pkg::term_t i_want,
    output drive_input_pkg::term_t o_term
);
    timeunit 1ns;
    timeprecision 100ps;
    // integral clear is only closed while regulation is switched off
    always_comb begin
        o_term = i_want;
        o_term.int_clr = i_want.int_clr & i_want.pid_dis;
    end
endmodule

// ---- verification/drive_input_terminal_functions_tb.sv ----
// testbench for the input terminal command logic
module drive_input_terminal_functions_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import drive_input_pkg::*;
    typedef struct packed {
        term_t t;
        logic [15:0] acc;
        logic [15:0] dec;
        logic [7:0] lim;
        logic pid_disable_input;
        logic po;
        logic [1:0] fs;
        logic [1:0] rs;
    } row_t;
    row_t rows [0:12];
    term_t want, i_term;
    assign_t i_assigned;
    logic i_core_clk = 0, i_resetn = 0, i_multi_speed = 0, i_analog_cmd = 0, i_jog = 0;
    logic i_trim_keep = 0, i_power_up = 1, i_trq_mode = 1, i_regen = 0, i_panel_run = 0;
    logic i_panel_dir = 0, i_running = 0;
    logic [1:0] i_freq_src = 2'h2, i_run_src = 2'h2;
    logic [15:0] i_base_freq = 16'h0100, i_max_freq = 16'h1000, i_trim_step = 16'h0010;
    logic [15:0] i_std_accel = 16'h0050, i_std_decel = 16'h0060, i_panel_freq = 16'h0222;
    logic [31:0] i_quad_limits = 32'h643c5028;
    logic [223:0] i_ramp_pairs;
    logic o_run, o_reverse, o_three_wire, o_pid_enable, o_integral_clear, o_freq_from_panel;
    logic o_p_only, o_override_stop;
    logic [15:0] o_freq, o_accel, o_decel, f;
    logic [1:0] o_eff_freq_src, o_eff_run_src;
    logic [7:0] o_torque_limit;
    int n_fail = 0, checks = 0, hi;

    // clock
    always #12.5 i_core_clk = ~i_core_clk;

    terminal_switches sw (.i_want(want), .o_term(i_term));
    drive_input_terminal_functions #(.FREQ_W(16), .TICK_CYCLES(4)) DUT (.i_core_clk,
        .i_resetn, .i_term, .i_assigned, .i_freq_src, .i_run_src, .i_multi_speed,
        .i_analog_cmd, .i_jog, .i_trim_keep, .i_power_up, .i_base_freq, .i_max_freq,
        .i_trim_step, .i_trq_mode, .i_quad_limits, .i_regen, .i_std_accel, .i_std_decel,
        .i_ramp_pairs, .i_panel_run, .i_panel_dir, .i_panel_freq, .i_running, .o_run,
        .o_reverse, .o_three_wire, .o_pid_enable, .o_integral_clear, .o_freq,
        .o_freq_from_panel, .o_eff_freq_src, .o_eff_run_src, .o_torque_limit, .o_accel,
        .o_decel, .o_p_only, .o_override_stop);

    // compare one value and count it
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic settle(input int n = 5);
        repeat (n) @(negedge i_core_clk);
    endtask

    // power cycle: reset for three cycles, then release the stored value
    task automatic power_cycle();
        i_resetn = 0;
        i_power_up = 1;
        settle(3);
        i_resetn = 1;
        settle(2);
        i_power_up = 0;
        settle();
    endtask

    // watchdog
    initial begin
        #(25 * 6000);
        n_fail++;
        give_verdict();
    end

    initial begin
        want = '0;
        i_assigned = '0;
        for (int n = 1; n < 8; n++) begin
            i_ramp_pairs[(2*n-2)*16 +: 16] = 16'(n * 16);
            i_ramp_pairs[(2*n-1)*16 +: 16] = 16'(n * 16 + 1);
        end
        for (int i = 0; i < 13; i++) begin
            rows[i] = '0;
            rows[i].acc = 16'h0050;
            rows[i].dec = 16'h0060;
            rows[i].lim = 8'h28;
            rows[i].pid_disable_input = 1;
            rows[i].fs = 2'h2;
            rows[i].rs = 2'h2;
        end
        for (int c = 1; c < 8; c++) begin
            rows[c].t.ramp_sel = 3'(c);
            rows[c].acc = 16'(c * 16);
            rows[c].dec = 16'(c * 16 + 1);
        end
        for (int k = 0; k < 4; k++) begin
            {rows[8+k].t.lim_sel1, rows[8+k].t.lim_sel0} = 2'(k);
            rows[8+k].lim = i_quad_limits[k*8 +: 8];
        end
        rows[8].t.pid_dis = 1;
        rows[8].pid_disable_input = 0;
        rows[9].t.p_only = 1;
        rows[9].po = 1;
        rows[10].t.local_force = 1;
        rows[10].fs = 2'h0;
        rows[11].t.remote_force = 1;
        {rows[11].fs, rows[11].rs} = 4'h5;
        {rows[12].t.local_force, rows[12].t.remote_force} = 2'h3;
        settle(3);
        chk("rst_pid", o_pid_enable, 16'h1);
        chk("rst_lim", o_torque_limit, 16'h00c8);
        chk("rst_acc", o_accel, 16'h012c);
        chk("rst_run", o_run, 16'h0);
        i_resetn = 1;
        settle(2);
        i_power_up = 0;
        settle();
        // table of steady terminal settings
        for (int i = 0; i < 13; i++) begin
            want = rows[i].t;
            settle();
            chk("accel", o_accel, rows[i].acc);
            chk("decel", o_decel, rows[i].dec);
            chk("tlim", o_torque_limit, rows[i].lim);
            chk("pid", o_pid_enable, rows[i].pid_disable_input);
            chk("p_only", o_p_only, rows[i].po);
            chk("fsrc", o_eff_freq_src, rows[i].fs);
            chk("rsrc", o_eff_run_src, rows[i].rs);
        end
        // torque limit enable assigned
        i_assigned.limit_en = 1;
        want = '0;
        want.lim_sel1 = 1;
        settle();
        chk("lim_off", o_torque_limit, 16'h00c8);
        want.limit_en = 1;
        settle();
        chk("lim_on", o_torque_limit, 16'h003c);
        // selectors only count in terminal mode
        i_trq_mode = 0;
        i_regen = 1;
        settle();
        chk("lim_mode0", o_torque_limit, 16'h0050);
        i_trq_mode = 1;
        i_regen = 0;
        // three-wire start, direction, stop
        want = '0;
        i_run_src = RUN_SRC_TERM;
        i_assigned = 4'he;
        want.stop = 1;
        settle();
        chk("3w", o_three_wire, 16'h1);
        chk("3w_idle", o_run, 16'h0);
        want.start = 1;
        settle(1);
        want.start = 0;
        settle();
        chk("3w_latch", o_run, 16'h1);
        want.dir = 1;
        settle();
        chk("3w_dir", o_reverse, 16'h1);
        want.stop = 0;
        want.fwd = 1;
        settle();
        chk("3w_stop", o_run, 16'h0);
        i_assigned.stop = 0;
        settle();
        chk("2w", o_three_wire, 16'h0);
        chk("2w_fwd", o_run, 16'h1);
        // integral clear gives one pulse per closing
        want = '0;
        want.pid_dis = 1;
        settle();
        want.int_clr = 1;
        hi = 0;
        repeat (8) begin
            @(negedge i_core_clk);
            if (o_integral_clear === 1'b1) hi++;
        end
        chk("iclr", 16'(hi), 16'h1);
        want = '0;
        settle();
        // frequency trim
        chk("base", o_freq, i_base_freq);
        want.up = 1;
        settle(40);
        want.up = 0;
        settle();
        chk("up", 16'(o_freq > i_base_freq), 16'h1);
        f = o_freq;
        settle(20);
        chk("hold", o_freq, f);
        want.down = 1;
        settle(20);
        want.down = 0;
        settle();
        chk("down", 16'(o_freq < f), 16'h1);
        for (int k = 0; k < 5; k++) begin
            i_freq_src = (k < 3) ? 2'h2 : ((k == 3) ? 2'h0 : 2'h1);
            {i_analog_cmd, i_jog, i_multi_speed} = {k == 1, k == 2, 1'b0};
            f = o_freq;
            want.up = 1;
            settle(20);
            want.up = 0;
            settle();
            chk("gate", 16'(o_freq != f), 16'(k == 0));
        end
        i_freq_src = 2'h1;
        i_multi_speed = 1;
        f = o_freq;
        want.ramp_sel = 3'h3;
        want.up = 1;
        settle(20);
        chk("trim_acc", o_accel, i_std_accel);
        chk("trim_dec", o_decel, i_std_decel);
        want.up = 0;
        settle();
        chk("multi", 16'(o_freq > f), 16'h1);
        chk("sel_acc", o_accel, 16'h0030);
        want.trim_clr = 1;
        settle();
        chk("clr", o_freq, i_base_freq);
        want.trim_clr = 0;
        want.up = 1;
        settle(20);
        want.up = 0;
        settle();
        f = o_freq;
        power_cycle();
        chk("mem0", o_freq, i_base_freq);
        i_trim_keep = TRIM_KEEP;
        want.up = 1;
        settle(20);
        want.up = 0;
        settle();
        f = o_freq;
        power_cycle();
        chk("mem1", o_freq, f);
        // operator override and stop on change while running
        i_freq_src = 2'h2;
        i_run_src = 2'h2;
        i_panel_run = 1;
        i_panel_dir = 1;
        want.oper = 1;
        // terminal run stays closed so the stop must hold after the flip
        want.fwd = 1;
        settle();
        chk("ovr", o_freq_from_panel, 16'h1);
        chk("ovr_f", o_freq, i_panel_freq);
        chk("ovr_dir", o_reverse, 16'h1);
        i_running = 1;
        want.oper = 0;
        settle();
        chk("ovr_stop", o_override_stop, 16'h1);
        chk("ovr_run", o_run, 16'h0);
        i_panel_run = 0;
        i_running = 0;
        want.fwd = 0;
        settle();
        chk("ovr_clr", o_override_stop, 16'h0);
        want.fwd = 1;
        settle();
        chk("ovr_resume", o_run, 16'h1);
        give_verdict();
    end
endmodule
